//--- pkg/mcu_decode_pkg.sv
// Operation
// RULE_01 - bank loads pointer, page loads status bits
// RULE_02 - memory read fetches word as data
// RULE_03 - bank, page, sleep one cycle; read 1/4
// RULE_04 - instruction rate is clock over one or four
// RULE_05 - divide choice comes from configuration configuration_word_a bit
// RULE_06 - skip instructions take two cycles when skipping
// RULE_07 - and forms, one cycle, zero flag only
// RULE_08 - or forms, one cycle, zero flag only
// RULE_09 - xor forms, one cycle, zero flag only
// RULE_10 - complement register, one cycle, zero flag
// RULE_11 - only listed flags; add/sub set carry, digit, zero
// RULE_12 - clear sets zero; watchdog clear sets timeout, powerdown
// RULE_13 - decrement updates zero; skip forms touch no flags
// RULE_14 - increment updates zero; skip forms touch no flags
// RULE_15 - rotates through carry update carry only
// RULE_16 - nibble swap changes no flag
// RULE_17 - bit ops use 3-bit index, no flags
// RULE_18 - skip-if-clear skips when bit is zero
// RULE_19 - moves to register/literal no flags; load updates zero
// RULE_20 - reverse subtract full flags; complement/test zero only
// RULE_21 - mode register read, write, literal load
// RULE_22 - accumulator to port control or option register
// RULE_23 - fixed full words beat port-control pattern
// RULE_24 - low five bits address, low eight literal
package mcu_decode_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_FSP = 8'h0C;
  localparam logic [7:0] OFF_MODE = 8'h10;
  localparam logic [7:0] OFF_OPTION = 8'h14;
  localparam logic [7:0] OFF_VIEW_ADDR = 8'h18;
  localparam logic [7:0] OFF_VIEW_DATA = 8'h1C;
  // field positions
  localparam int CTRL_HALT_BIT = 0;
  localparam int CONFIGURATION_WORD_A_TURBO_BIT = 0;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  // reset values
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [3:0] RST_MODE = 4'hF;
  // timing and port select range
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam logic [1:0] IREAD_TURBO_EXTRA = 2'h3;
  localparam logic [3:0] PORT_SEL_FIRST = 4'h5;
  localparam logic [3:0] PORT_SEL_LAST = 4'hB;
  typedef enum logic [5:0] {
    OP_NOP, OP_OTHER, OP_AND_F, OP_AND_W, OP_AND_L, OP_OR_F, OP_OR_W, OP_OR_L,
    OP_XOR_F, OP_XOR_W, OP_XOR_L, OP_NOT_F, OP_NOT_W, OP_ADD_F, OP_ADD_W,
    OP_SUB_F, OP_SUB_W, OP_CLR_F, OP_CLR_W, OP_CLR_WDT, OP_DEC_F, OP_DEC_W,
    OP_DECREMENT_SKIP_ZERO_F, OP_DECREMENT_SKIP_ZERO_W, OP_INC_F, OP_INC_W, OP_INCREMENT_SKIP_ZERO_F, OP_INCREMENT_SKIP_ZERO_W,
    OP_RL_F, OP_RL_W, OP_RR_F, OP_RR_W, OP_SWAP_F, OP_SWAP_W, OP_CLRB, OP_SETB,
    OP_SB, OP_SNB, OP_MOV_F, OP_MOV_W, OP_MOV_L, OP_TEST, OP_MODE_RD, OP_MODE_WR,
    OP_MODE_L, OP_PORT_WR, OP_OPTION_WR, OP_BANK, OP_PAGE, OP_IREAD, OP_SLEEP
  } op_t;
endpackage : mcu_decode_pkg

//--- src/mcu_instruction_decoder.sv
`timescale 1ns/1ps
module mcu_instruction_decoder (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // configuration configuration_word_a word
  input wire logic [11:0] configuration_word_a_i,
  // instruction stream
  input wire logic [11:0] instr_word_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  // program memory data read
  output logic [11:0] iread_addr_o,
  input wire logic [11:0] iread_data_i,
  // port control write
  output logic port_ctrl_we_o,
  output logic [3:0] port_ctrl_sel_o,
  output logic [3:0] port_ctrl_mode_o,
  output logic [7:0] port_ctrl_data_o,
  // system
  output logic wdt_clear_o,
  output logic powerdown_o,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import mcu_decode_pkg::*;

  typedef struct packed {
    logic [7:0] w, status, file_select_pointer;
    logic [3:0] mode;
    logic [7:0] option;
    logic [31:0][7:0] regs;
    logic [1:0] div_cnt, wait_cnt;
    logic rd_pend, skip_pend, asleep, halt;
    logic [11:0] rd_addr;
    logic [4:0] view_addr;
    logic [31:0] prdata;
    logic pslverr, port_we;
    logic [3:0] port_sel, port_mode;
    logic [7:0] port_data;
    logic wdt_clr;
  } core_t;

  core_t st;
  core_t nx;

  // fixed full words are listed before the wider patterns
  function automatic op_t decode(input logic [11:0] iw);
    op_t op;
    op = OP_OTHER;
    // RULE_23 fixed words first
    casez (iw)
      12'b0000_0000_0000: op = OP_NOP;
      12'b0000_0000_0010: op = OP_OPTION_WR;
      12'b0000_0000_0011: op = OP_SLEEP;
      12'b0000_0000_0100: op = OP_CLR_WDT;
      12'b0000_0100_0000: op = OP_CLR_W;
      12'b0000_0100_0001: op = OP_IREAD;
      12'b0000_0100_0010: op = OP_MODE_RD;
      12'b0000_0100_0011: op = OP_MODE_WR;
      12'b0000_0101_????: op = OP_MODE_L;
      12'b0000_0001_1???: op = OP_BANK;
      12'b0000_0001_0???: op = OP_PAGE;
      12'b0000_0000_????: begin
        if (iw[3:0] >= PORT_SEL_FIRST && iw[3:0] <= PORT_SEL_LAST) begin
          op = OP_PORT_WR;
        end
      end
      12'b0000_001?_????: op = OP_MOV_F;
      12'b0000_011?_????: op = OP_CLR_F;
      12'b0000_100?_????: op = OP_SUB_W;
      12'b0000_101?_????: op = OP_SUB_F;
      12'b0000_110?_????: op = OP_DEC_W;
      12'b0000_111?_????: op = OP_DEC_F;
      12'b0001_000?_????: op = OP_OR_W;
      12'b0001_001?_????: op = OP_OR_F;
      12'b0001_010?_????: op = OP_AND_W;
      12'b0001_011?_????: op = OP_AND_F;
      12'b0001_100?_????: op = OP_XOR_W;
      12'b0001_101?_????: op = OP_XOR_F;
      12'b0001_110?_????: op = OP_ADD_W;
      12'b0001_111?_????: op = OP_ADD_F;
      12'b0010_000?_????: op = OP_MOV_W;
      12'b0010_001?_????: op = OP_TEST;
      12'b0010_010?_????: op = OP_NOT_W;
      12'b0010_011?_????: op = OP_NOT_F;
      12'b0010_100?_????: op = OP_INC_W;
      12'b0010_101?_????: op = OP_INC_F;
      12'b0010_110?_????: op = OP_DECREMENT_SKIP_ZERO_W;
      12'b0010_111?_????: op = OP_DECREMENT_SKIP_ZERO_F;
      12'b0011_000?_????: op = OP_RR_W;
      12'b0011_001?_????: op = OP_RR_F;
      12'b0011_010?_????: op = OP_RL_W;
      12'b0011_011?_????: op = OP_RL_F;
      12'b0011_100?_????: op = OP_SWAP_W;
      12'b0011_101?_????: op = OP_SWAP_F;
      12'b0011_110?_????: op = OP_INCREMENT_SKIP_ZERO_W;
      12'b0011_111?_????: op = OP_INCREMENT_SKIP_ZERO_F;
      12'b0100_????_????: op = OP_CLRB;
      12'b0101_????_????: op = OP_SETB;
      12'b0110_????_????: op = OP_SNB;
      12'b0111_????_????: op = OP_SB;
      12'b1100_????_????: op = OP_MOV_L;
      12'b1101_????_????: op = OP_OR_L;
      12'b1110_????_????: op = OP_AND_L;
      12'b1111_????_????: op = OP_XOR_L;
      default: op = OP_OTHER;
    endcase
    return op;
  endfunction : decode

  logic turbo, tick, ready, take, setup, access;
  op_t op;
  logic [4:0] fa, nib;
  logic [7:0] fv, lit, wv, res;
  logic [8:0] wide;
  logic wr_f, wr_w, upd_z, upd_c, upd_dc, new_c, new_dc;

  // RULE_05 configuration_word_a bit picks divider
  assign turbo = configuration_word_a_i[CONFIGURATION_WORD_A_TURBO_BIT];
  // RULE_04 one tick per instruction cycle
  assign tick = turbo | (st.div_cnt == DIV_LAST);
  // a pending data read holds the pipe until its last cycle
  assign ready = tick & (st.wait_cnt == 2'h0) & ~st.asleep & ~st.halt;
  assign take = ready & instr_valid_i;
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;

  always_comb begin
    nx = st;
    {nx.port_we, nx.wdt_clr} = 2'h0;
    op = decode(instr_word_i);
    // RULE_24 operand fields
    fa = instr_word_i[4:0];
    lit = instr_word_i[7:0];
    fv = st.regs[fa];
    res = 8'h00;
    wide = 9'h000;
    nib = 5'h00;
    {wr_f, wr_w, upd_z, upd_c, upd_dc, new_c, new_dc} = 7'h00;
    nx.div_cnt = turbo ? 2'h0 : st.div_cnt + 2'h1;
    if (tick && st.wait_cnt != 2'h0) begin
      nx.wait_cnt = st.wait_cnt - 2'h1;
    end
    // RULE_02 read word lands as data
    if (tick && st.wait_cnt == 2'h0 && st.rd_pend) begin
      nx.w = iread_data_i[7:0];
      nx.mode = iread_data_i[11:8];
      nx.rd_pend = 1'b0;
    end
    wv = nx.w;
    if (take && st.skip_pend) begin
      // RULE_06 discarded word costs one cycle
      nx.skip_pend = 1'b0;
    end else if (take) begin
      unique case (op)
        // RULE_07 and forms
        OP_AND_F, OP_AND_W, OP_AND_L: begin
          res = ((op == OP_AND_L) ? lit : fv) & wv;
          wr_f = (op == OP_AND_F);
          wr_w = (op != OP_AND_F);
          upd_z = 1'b1;
        end
        // RULE_08 or forms
        OP_OR_F, OP_OR_W, OP_OR_L: begin
          res = ((op == OP_OR_L) ? lit : fv) | wv;
          wr_f = (op == OP_OR_F);
          wr_w = (op != OP_OR_F);
          upd_z = 1'b1;
        end
        // RULE_09 xor forms
        OP_XOR_F, OP_XOR_W, OP_XOR_L: begin
          res = ((op == OP_XOR_L) ? lit : fv) ^ wv;
          wr_f = (op == OP_XOR_F);
          wr_w = (op != OP_XOR_F);
          upd_z = 1'b1;
        end
        // RULE_10 complement, zero only
        OP_NOT_F, OP_NOT_W: begin
          res = ~fv;
          wr_f = (op == OP_NOT_F);
          wr_w = (op == OP_NOT_W);
          upd_z = 1'b1;
        end
        // RULE_11 add sets three flags
        OP_ADD_F, OP_ADD_W: begin
          wide = {1'b0, fv} + {1'b0, wv};
          nib = {1'b0, fv[3:0]} + {1'b0, wv[3:0]};
          res = wide[7:0];
          new_c = wide[8];
          new_dc = nib[4];
          wr_f = (op == OP_ADD_F);
          wr_w = (op == OP_ADD_W);
          {upd_z, upd_c, upd_dc} = 3'h7;
        end
        // RULE_20 carry means no borrow
        OP_SUB_F, OP_SUB_W: begin
          wide = {1'b0, fv} - {1'b0, wv};
          nib = {1'b0, fv[3:0]} - {1'b0, wv[3:0]};
          res = wide[7:0];
          new_c = ~wide[8];
          new_dc = ~nib[4];
          wr_f = (op == OP_SUB_F);
          wr_w = (op == OP_SUB_W);
          {upd_z, upd_c, upd_dc} = 3'h7;
        end
        // RULE_12 clears set zero
        OP_CLR_F, OP_CLR_W: begin
          res = 8'h00;
          wr_f = (op == OP_CLR_F);
          wr_w = (op == OP_CLR_W);
          upd_z = 1'b1;
        end
        // RULE_12 watchdog clear flags
        OP_CLR_WDT: begin
          nx.wdt_clr = 1'b1;
          nx.status[ST_TO] = 1'b1;
          nx.status[ST_PD] = 1'b1;
        end
        // RULE_13 decrement forms
        OP_DEC_F, OP_DEC_W, OP_DECREMENT_SKIP_ZERO_F, OP_DECREMENT_SKIP_ZERO_W: begin
          res = fv - 8'h01;
          wr_f = (op == OP_DEC_F) | (op == OP_DECREMENT_SKIP_ZERO_F);
          wr_w = (op == OP_DEC_W) | (op == OP_DECREMENT_SKIP_ZERO_W);
          upd_z = (op == OP_DEC_F) | (op == OP_DEC_W);
          nx.skip_pend = ~upd_z & (res == 8'h00);
        end
        // RULE_14 increment forms
        OP_INC_F, OP_INC_W, OP_INCREMENT_SKIP_ZERO_F, OP_INCREMENT_SKIP_ZERO_W: begin
          res = fv + 8'h01;
          wr_f = (op == OP_INC_F) | (op == OP_INCREMENT_SKIP_ZERO_F);
          wr_w = (op == OP_INC_W) | (op == OP_INCREMENT_SKIP_ZERO_W);
          upd_z = (op == OP_INC_F) | (op == OP_INC_W);
          nx.skip_pend = ~upd_z & (res == 8'h00);
        end
        // RULE_15 rotates through carry
        OP_RL_F, OP_RL_W: begin
          res = {fv[6:0], st.status[ST_C]};
          new_c = fv[7];
          upd_c = 1'b1;
          wr_f = (op == OP_RL_F);
          wr_w = (op == OP_RL_W);
        end
        OP_RR_F, OP_RR_W: begin
          res = {st.status[ST_C], fv[7:1]};
          new_c = fv[0];
          upd_c = 1'b1;
          wr_f = (op == OP_RR_F);
          wr_w = (op == OP_RR_W);
        end
        // RULE_16 nibble swap, flags kept
        OP_SWAP_F, OP_SWAP_W: begin
          res = {fv[3:0], fv[7:4]};
          wr_f = (op == OP_SWAP_F);
          wr_w = (op == OP_SWAP_W);
        end
        // RULE_17 bit clear and set
        OP_CLRB, OP_SETB: begin
          res = fv;
          res[instr_word_i[7:5]] = (op == OP_SETB);
          wr_f = 1'b1;
        end
        // RULE_17 skip when bit set
        OP_SB: begin
          nx.skip_pend = fv[instr_word_i[7:5]];
        end
        // RULE_18 skip when bit clear
        OP_SNB: begin
          nx.skip_pend = ~fv[instr_word_i[7:5]];
        end
        // RULE_19 moves
        OP_MOV_F: begin
          res = wv;
          wr_f = 1'b1;
        end
        OP_MOV_W: begin
          res = fv;
          wr_w = 1'b1;
          upd_z = 1'b1;
        end
        OP_MOV_L: begin
          res = lit;
          wr_w = 1'b1;
        end
        // RULE_20 zero test only
        OP_TEST: begin
          res = fv;
          upd_z = 1'b1;
        end
        // RULE_21 mode register access
        OP_MODE_RD: begin
          res = {4'h0, st.mode};
          wr_w = 1'b1;
        end
        OP_MODE_WR: nx.mode = wv[3:0];
        OP_MODE_L: nx.mode = instr_word_i[3:0];
        // RULE_22 port control and option
        OP_PORT_WR: begin
          nx.port_we = 1'b1;
          nx.port_sel = instr_word_i[3:0];
          nx.port_mode = st.mode;
          nx.port_data = wv;
        end
        OP_OPTION_WR: nx.option = wv;
        // RULE_01 bank and page
        OP_BANK: nx.file_select_pointer[7:5] = instr_word_i[2:0];
        OP_PAGE: nx.status[7:5] = instr_word_i[2:0];
        // RULE_03 read spans four turbo cycles
        OP_IREAD: begin
          nx.rd_addr = {st.mode, wv};
          nx.rd_pend = 1'b1;
          nx.wait_cnt = turbo ? IREAD_TURBO_EXTRA : 2'h0;
        end
        // RULE_03 sleep in one cycle
        OP_SLEEP: begin
          nx.asleep = 1'b1;
          nx.status[ST_TO] = 1'b1;
          nx.status[ST_PD] = 1'b0;
        end
        OP_NOP, OP_OTHER: res = 8'h00;
      endcase
      // RULE_11 only listed flags written
      if (wr_f) begin
        nx.regs[fa] = res;
      end
      if (wr_w) begin
        nx.w = res;
      end
      if (upd_z) begin
        nx.status[ST_Z] = (res == 8'h00);
      end
      if (upd_c) begin
        nx.status[ST_C] = new_c;
      end
      if (upd_dc) begin
        nx.status[ST_DC] = new_dc;
      end
    end
    // read data is captured in the setup phase so prdata comes from a flop
    if (setup) begin
      nx.pslverr = 1'b0;
      nx.prdata = 32'h0000_0000;
      case (paddr_i)
        OFF_CTRL: nx.prdata = {31'h0000_0000, st.halt};
        OFF_ACC: nx.prdata = {24'h00_0000, st.w};
        OFF_STATUS: nx.prdata = {24'h00_0000, st.status};
        OFF_FSP: nx.prdata = {24'h00_0000, st.file_select_pointer};
        OFF_MODE: nx.prdata = {28'h000_0000, st.mode};
        OFF_OPTION: nx.prdata = {24'h00_0000, st.option};
        OFF_VIEW_ADDR: nx.prdata = {27'h000_0000, st.view_addr};
        OFF_VIEW_DATA: nx.prdata = {24'h00_0000, st.regs[st.view_addr]};
        default: nx.pslverr = 1'b1;
      endcase
    end
    // software writes override the core in the same cycle; halt first
    if (access && pwrite_i && !st.pslverr && pstrb_i[0]) begin
      case (paddr_i)
        OFF_CTRL: nx.halt = pwdata_i[CTRL_HALT_BIT];
        OFF_ACC: nx.w = pwdata_i[7:0];
        OFF_STATUS: nx.status = pwdata_i[7:0];
        OFF_VIEW_ADDR: nx.view_addr = pwdata_i[4:0];
        OFF_VIEW_DATA: nx.regs[st.view_addr] = pwdata_i[7:0];
        default: nx.halt = nx.halt;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.status <= RST_STATUS;
      st.option <= RST_OPTION;
      st.mode <= RST_MODE;
    end else begin
      st <= nx;
    end
  end

  assign instr_ready_o = ready;
  assign iread_addr_o = st.rd_addr;
  assign port_ctrl_we_o = st.port_we;
  assign port_ctrl_sel_o = st.port_sel;
  assign port_ctrl_mode_o = st.port_mode;
  assign port_ctrl_data_o = st.port_data;
  assign wdt_clear_o = st.wdt_clr;
  assign powerdown_o = st.asleep;
  assign prdata_o = st.prdata;
  assign pready_o = access;
  assign pslverr_o = access & st.pslverr;
endmodule : mcu_instruction_decoder

//--- test/prog_mem_model.sv
`timescale 1ns/1ps
module prog_mem_model #(
  parameter logic [11:0] FILL = 12'hA5C
) (
  // read address from the decoder
  input wire logic [11:0] addr_i,
  // program word back
  output logic [11:0] data_o
);
  // every address gives its own word, so a wrong address shows up as wrong data
  assign data_o = addr_i ^ FILL;
endmodule : prog_mem_model

//--- test/mcu_instruction_decoder_asserts.sv
`timescale 1ns/1ps
module mcu_decoder_checker (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // instruction side
  input wire logic [11:0] configuration_word_a_i,
  input wire logic [11:0] instr_word_i,
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  // outputs under watch
  input wire logic port_ctrl_we_o,
  input wire logic [3:0] port_ctrl_sel_o,
  input wire logic wdt_clear_o,
  input wire logic powerdown_o
);
  import mcu_decode_pkg::*;
  logic take;
  logic wdt_taken;
  logic [3:0] last_nib;
  assign take = instr_valid_i && instr_ready_o;
  always_ff @(posedge clk_sys_i) begin
    wdt_taken <= nrst_i && take && (instr_word_i == 12'h004);
    last_nib <= instr_word_i[3:0];
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  chk_compat_spacing: assert property (
    !configuration_word_a_i[0] && instr_ready_o |=> !instr_ready_o [*3])
    else $error("ready closer than four clocks in divide-by-four mode");
  chk_iread_stall: assert property (
    take && configuration_word_a_i[0] && instr_word_i == 12'h041
    |=> !instr_ready_o [*3] ##1 instr_ready_o)
    else $error("program read in turbo did not span four clocks");
  chk_sleep_enter: assert property (
    take && instr_word_i == 12'h003 |=> powerdown_o)
    else $error("sleep did not raise powerdown");
  chk_sleep_hold: assert property (
    powerdown_o |-> !instr_ready_o ##1 powerdown_o)
    else $error("powerdown dropped or words accepted while asleep");
  chk_wdt_cause: assert property (
    wdt_clear_o |-> wdt_taken)
    else $error("watchdog clear pulse without its instruction");
  chk_wdt_effect: assert property (
    wdt_taken |-> wdt_clear_o)
    else $error("watchdog clear instruction gave no pulse");
  chk_port_pulse: assert property (
    take && instr_word_i[11:4] == 8'h00 && instr_word_i[3:0] inside {[4'h5:4'hB]}
    |=> port_ctrl_we_o)
    else $error("port control write gave no strobe");
  chk_port_select: assert property (
    port_ctrl_we_o |-> port_ctrl_sel_o == last_nib && $past(take))
    else $error("port control strobe with wrong select");
  chk_fixed_words: assert property (
    take && (instr_word_i == 12'h002 || instr_word_i == 12'h003 || instr_word_i == 12'h004)
    |=> !port_ctrl_we_o)
    else $error("fixed word decoded as port control write");
  cover property (take && instr_word_i == 12'h041);
  cover property (wdt_clear_o);
  cover property (port_ctrl_we_o);
endmodule : mcu_decoder_checker
bind mcu_instruction_decoder mcu_decoder_checker chk_i (
  .clk_sys_i,
  .nrst_i,
  .configuration_word_a_i,
  .instr_word_i,
  .instr_valid_i,
  .instr_ready_o,
  .port_ctrl_we_o,
  .port_ctrl_sel_o,
  .wdt_clear_o,
  .powerdown_o
);

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  import mcu_decode_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [11:0] configuration_word_a = 12'h001;
  logic [11:0] word = 12'h000;
  logic [11:0] cur = 12'h000;
  logic valid = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ready, pready, pslverr, port_we, wdt_clr, pdown, slverr_seen;
  logic [31:0] prdata, rv;
  logic [11:0] iaddr, idata;
  logic [3:0] port_sel, port_mode, seen_sel, seen_mode;
  logic [7:0] port_data, seen_data;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int port_cnt = 0;
  int wdt_cnt = 0;
  int tk[$];
  // word, file value, then expected acc, status and file value
  logic [43:0] la[$] = '{44'h155_F0_30_1B_F0, 44'h175_F0_3C_1B_30, 44'hE0F_F0_0C_1B_F0,
    44'hEC3_F0_00_1F_F0, 44'hD03_F0_3F_1B_F0, 44'h135_F0_3C_1B_FC, 44'h195_F0_CC_1B_F0,
    44'h1B5_F0_3C_1B_CC, 44'hF3C_F0_00_1F_F0, 44'h275_F0_3C_1B_0F, 44'h1D5_F0_2C_19_F0,
    44'h1F5_F0_3C_19_2C, 44'h0B5_F0_3C_19_B4, 44'h1D5_C4_00_1F_C4, 44'h0B5_10_3C_18_D4,
    44'h075_F0_3C_1F_00, 44'h040_F0_00_1F_F0};
  logic [43:0] lb[$] = '{44'h0F5_F0_3C_1B_EF, 44'h0F5_01_3C_1F_00, 44'h2B5_F0_3C_1B_F1,
    44'h2B5_FF_3C_1F_00, 44'h0D5_F0_EF_1B_F0, 44'h295_F0_F1_1B_F0, 44'h375_F0_3C_1B_E1,
    44'h335_F0_3C_1A_F8, 44'h355_F0_E1_1B_F0, 44'h315_F0_F8_1A_F0, 44'h3B5_F0_3C_1B_0F,
    44'h395_F0_0F_1B_F0, 44'h4B5_F0_3C_1B_D0, 44'h575_F0_3C_1B_F8, 44'h035_F0_3C_1B_3C,
    44'h215_F0_F0_1B_F0, 44'h215_00_00_1F_00, 44'hC00_F0_00_1B_F0, 44'h095_F0_B4_19_F0,
    44'h255_F0_0F_1B_F0, 44'h235_00_3C_1F_00};
  logic [43:0] sk[$] = '{44'h2F5_01_3C_1B_00, 44'h2F5_05_55_1B_04, 44'h3F5_FF_3C_1B_00,
    44'h3F5_10_55_1B_11, 44'h2D5_01_00_1B_01, 44'h3D5_FF_00_1B_FF, 44'h7F5_80_3C_1B_80,
    44'h7F5_7F_55_1B_7F, 44'h6F5_80_55_1B_80, 44'h615_80_3C_1B_80};
  mcu_instruction_decoder uut (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .configuration_word_a_i(configuration_word_a),
    .instr_word_i(word),
    .instr_valid_i(valid),
    .instr_ready_o(ready),
    .iread_addr_o(iaddr),
    .iread_data_i(idata),
    .port_ctrl_we_o(port_we),
    .port_ctrl_sel_o(port_sel),
    .port_ctrl_mode_o(port_mode),
    .port_ctrl_data_o(port_data),
    .wdt_clear_o(wdt_clr),
    .powerdown_o(pdown),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .pstrb_i(4'hF),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr)
  );
  prog_mem_model mem (
    .addr_i(iaddr),
    .data_o(idata)
  );
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // hang guard: the whole run needs well under two thousand clocks
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // sampled mid-cycle, where ready and the pulses have settled
  always @(negedge clk_sys_i) begin
    if (port_we === 1'b1) begin
      port_cnt++;
      seen_sel = port_sel;
      seen_mode = port_mode;
      seen_data = port_data;
    end
    if (wdt_clr === 1'b1) wdt_cnt++;
    if (valid && ready === 1'b1) tk.push_back(cyc);
  end
  task automatic tally_and_finish();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h after word %h", n, e, g, cur);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rv = prdata;
    slverr_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rv);
  endtask : rd
  task automatic run(input logic [11:0] a, input logic [11:0] b, input logic two);
    @(posedge clk_sys_i);
    tk.delete();
    cur = a;
    word <= a;
    valid <= 1'b1;
    // ready is combinational: look at it mid-cycle, then let the taking edge pass
    do @(negedge clk_sys_i); while (ready !== 1'b1);
    @(posedge clk_sys_i);
    if (two) begin
      word <= b;
      do @(negedge clk_sys_i); while (ready !== 1'b1);
      @(posedge clk_sys_i);
    end
    valid <= 1'b0;
  endtask : run
  // a refused word must never be taken
  task automatic offer(input logic [11:0] a);
    @(posedge clk_sys_i);
    tk.delete();
    word <= a;
    valid <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    valid <= 1'b0;
    chk("takes while refused", 32'h0, tk.size());
  endtask : offer
  task automatic row(input logic [43:0] r, input logic tail);
    wr(OFF_VIEW_DATA, {24'h0, r[31:24]});
    wr(OFF_ACC, 32'h3C);
    wr(OFF_STATUS, 32'h1B);
    run(r[43:32], 12'hC55, tail);
    rd("acc", OFF_ACC, {24'h0, r[23:16]});
    rd("status", OFF_STATUS, {24'h0, r[15:8]});
    rd("file reg", OFF_VIEW_DATA, {24'h0, r[7:0]});
  endtask : row
  initial begin
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd("acc", OFF_ACC, 32'h0);
    rd("status", OFF_STATUS, 32'h18);
    rd("pointer", OFF_FSP, 32'h0);
    rd("mode", OFF_MODE, 32'h0F);
    rd("option", OFF_OPTION, 32'hFF);
    rd("unmapped", 8'h20, 32'h0);
    chk("unmapped error", 32'h1, slverr_seen);
    wr(OFF_MODE, 32'h05);
    rd("read-only mode", OFF_MODE, 32'h0F);
    wr(OFF_VIEW_ADDR, 32'h15);
    foreach (la[i]) row(la[i], 1'b0);
    foreach (lb[i]) row(lb[i], 1'b0);
    foreach (sk[i]) row(sk[i], 1'b1);
    run(12'h05A, 12'h0, 1'b0);
    rd("mode", OFF_MODE, 32'h0A);
    wr(OFF_ACC, 32'h07);
    run(12'h043, 12'h0, 1'b0);
    wr(OFF_ACC, 32'h0);
    run(12'h042, 12'h0, 1'b0);
    rd("acc", OFF_ACC, 32'h07);
    for (int s = 5; s <= 11; s++) begin
      wr(OFF_ACC, 32'h40 + s);
      run({8'h00, 4'(s)}, 12'h0, 1'b0);
      repeat (2) @(posedge clk_sys_i);
      chk("port sel", s, {28'h0, seen_sel});
      chk("port data", 32'h40 + s, {24'h0, seen_data});
      chk("port mode", 32'h07, {28'h0, seen_mode});
    end
    wr(OFF_ACC, 32'h3E);
    run(12'h002, 12'h0, 1'b0);
    rd("option", OFF_OPTION, 32'h3E);
    chk("port writes", 32'h7, port_cnt);
    wr(OFF_STATUS, 32'h0);
    run(12'h004, 12'h0, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    chk("wdt pulses", 32'h1, wdt_cnt);
    rd("status", OFF_STATUS, 32'h18);
    run(12'h01B, 12'h015, 1'b1);
    rd("pointer", OFF_FSP, 32'h60);
    rd("status", OFF_STATUS, 32'hB8);
    run(12'h053, 12'h0, 1'b0);
    wr(OFF_ACC, 32'h21);
    run(12'h041, 12'hD00, 1'b1);
    chk("read spacing", 32'h4, tk[1] - tk[0]);
    rd("acc", OFF_ACC, 32'h7D);
    rd("mode", OFF_MODE, 32'h09);
    run(12'hC11, 12'hC22, 1'b1);
    chk("turbo spacing", 32'h1, tk[1] - tk[0]);
    wr(OFF_CTRL, 32'h1);
    offer(12'hC77);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STATUS, 32'h0);
    run(12'h003, 12'h0, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    chk("powerdown", 32'h1, {31'h0, pdown});
    rd("status", OFF_STATUS, 32'h10);
    offer(12'hC77);
    rd("acc", OFF_ACC, 32'h22);
    nrst_i <= 1'b0;
    configuration_word_a <= 12'h000;
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    run(12'hC11, 12'hC22, 1'b1);
    chk("compat spacing", 32'h4, tk[1] - tk[0]);
    run(12'h053, 12'h0, 1'b0);
    wr(OFF_ACC, 32'h21);
    run(12'h041, 12'hD00, 1'b1);
    chk("compat read spacing", 32'h4, tk[1] - tk[0]);
    rd("acc", OFF_ACC, 32'h7D);
    tally_and_finish();
  end
endmodule : tb
